/* File: tocc_defs.svh */
// Constants for the output-compare control block.
// Assumes inclusion by bare name from the package and design files.
`ifndef TOCC_DEFS_SVH
`define TOCC_DEFS_SVH
// Register word offsets (word indices on address bits 5..2, one aligned word each)
`define TOCC_OFS_FORCE 4'h0
`define TOCC_OFS_MASK 4'h1
`define TOCC_OFS_DATA 4'h2
`define TOCC_OFS_CNT_HI 4'h3
`define TOCC_OFS_CNT_LO 4'h4
`define TOCC_OFS_ACTION 4'h5
`define TOCC_OFS_ACCUM 4'h6
`define TOCC_OFS_CMP1 4'h7
`define TOCC_OFS_CMP2 4'h8
`define TOCC_OFS_CMP3 4'h9
`define TOCC_OFS_CMP4 4'ha
`define TOCC_OFS_CMP5 4'hb
`define TOCC_OFS_PRESC 4'hc
`define TOCC_OFS_PORT 4'hd
// Field positions
`define TOCC_PIN_LSB 3
`define TOCC_PIN_MSB 7
`define TOCC_DIR4_BIT 2
// Reset values
`define TOCC_RST_BYTE 8'h00
`define TOCC_RST_WORD 16'hffff
`define TOCC_RST_PRESC 8'h00
// Action selector codes {mode,level}
`define TOCC_ACT_OFF 2'b00
`define TOCC_ACT_TOGGLE 2'b01
`define TOCC_ACT_LOW 2'b10
`define TOCC_ACT_HIGH 2'b11
`endif

/* File: tocc_pkg.sv */
// Types for the output-compare control block.
// Assumes tocc_defs.svh is on the include path.
`include "tocc_defs.svh"
package tocc_pkg;
  typedef logic [1:0] tocc_action_type;
  typedef enum logic [2:0] {
    TOCC_IDLE = 3'b001,
    TOCC_WAIT = 3'b010,
    TOCC_DONE = 3'b100
  } tocc_bus_state_type;
endpackage : tocc_pkg

/* File: tocc_pin_if.sv */
// Interface carrying per-pin action requests between the control core and pin logic.
// Assumes one clock domain; requests driven by tocc_top, pin state and enables driven back by tocc_pin_logic.
`timescale 1ns/10ps
`default_nettype none
interface tocc_pin_if;
  logic [4:0] ch1_hit;
  logic [4:0] ch1_val;
  logic [4:0] nch_hit;
  logic [9:0] nch_act;
  logic [4:0] pin_q;
  logic [4:0] pin_en;
  modport core (output ch1_hit, output ch1_val, output nch_hit, output nch_act,
    input pin_q, input pin_en);
  modport pins (input ch1_hit, input ch1_val, input nch_hit, input nch_act,
    output pin_q, output pin_en);
endinterface : tocc_pin_if
`default_nettype wire

/* File: tocc_pin_logic.sv */
// Port A pin state for bits 7..3 driven by compare actions.
// Assumes one-cycle action requests from the control core on the same clock.
`timescale 1ns/10ps
`default_nettype none
module tocc_pin_logic (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  tocc_pin_if.pins pif
);
  import tocc_pkg::*;
  `include "tocc_defs.svh"

  logic [4:0] pin_q;
  logic [4:0] en_q;

  // --------------------------------------------------------------
  // Pin update: channel one wins over channels two to five
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_q <= 5'h00;
      en_q <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (pif.ch1_hit[i]) begin
          pin_q[i] <= pif.ch1_val[i];
          en_q[i] <= 1'b1;
        end else if (pif.nch_hit[i]) begin
          unique case (pif.nch_act[2*i +: 2])
            `TOCC_ACT_OFF: en_q[i] <= 1'b0;
            `TOCC_ACT_TOGGLE: begin
              pin_q[i] <= ~pin_q[i];
              en_q[i] <= 1'b1;
            end
            `TOCC_ACT_LOW: begin
              pin_q[i] <= 1'b0;
              en_q[i] <= 1'b1;
            end
            `TOCC_ACT_HIGH: begin
              pin_q[i] <= 1'b1;
              en_q[i] <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  assign pif.pin_q = pin_q;
  assign pif.pin_en = en_q;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_high_sets_pin: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (pif.nch_hit[0] && !pif.ch1_hit[0] && pif.nch_act[1:0] == `TOCC_ACT_HIGH)
    |=> (pin_q[0] && en_q[0]))
    else $error("set action did not drive pin high");
  a_toggle_flips_pin: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (pif.nch_hit[1] && !pif.ch1_hit[1] && pif.nch_act[3:2] == `TOCC_ACT_TOGGLE)
    |=> (pin_q[1] != $past(pin_q[1])))
    else $error("toggle action did not flip pin");
  a_ch1_copies_data: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    pif.ch1_hit[4] |=> (pin_q[4] == $past(pif.ch1_val[4])))
    else $error("channel one data not copied to pin");
endmodule : tocc_pin_logic
`default_nettype wire

/* File: tocc_top.sv */
// Output-compare control: forced compares, channel-one mask/data, buffered counter
// read, two-bit actions for channels two to five, Avalon-MM register slave.
// Assumes an Avalon-MM master on core_clk_i and that port A bits 7..3 are pins.
`timescale 1ns/10ps
`default_nettype none
module tocc_top #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [4:0] port_a_o,
  output logic [4:0] port_a_oe_o
);
  import tocc_pkg::*;
  `include "tocc_defs.svh"

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  logic [4:0] mask_q;
  logic [4:0] data_q;
  logic [7:0] action_q;
  logic dir4_q;
  logic [7:0] presc_q;
  logic [7:0] pdiv_q;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0] lo_buf_q;
  logic [CNT_W-1:0] cmp_q [5];
  logic [4:0] force_q;
  logic [4:0] match_q;
  logic [31:0] rdata_q;
  tocc_bus_state_type st_q;

  logic [3:0] idx;
  logic hit_ok;
  logic wr_acc;
  logic rd_acc;
  logic tick;
  logic hi_snap;

  tocc_pin_if pif ();

  function automatic logic [7:0] pin_byte(input logic [4:0] v);
    pin_byte = {v, 3'b000};
  endfunction : pin_byte

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
      input logic be);
    merge_byte = be ? wd[7:0] : old;
  endfunction : merge_byte

  assign idx = avs_address_i[5:2];
  assign hit_ok = (avs_address_i[1:0] == 2'b00) && (idx <= `TOCC_OFS_PORT);

  // --------------------------------------------------------------
  // Bus handshake: one wait state, answer on second edge
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= TOCC_IDLE;
    end else begin
      unique case (st_q)
        TOCC_IDLE: if (avs_read_i || avs_write_i) st_q <= TOCC_WAIT;
        TOCC_WAIT: st_q <= TOCC_DONE;
        TOCC_DONE: st_q <= TOCC_IDLE;
        default: st_q <= TOCC_IDLE;
      endcase
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (st_q != TOCC_WAIT);
  assign wr_acc = avs_write_i && (st_q == TOCC_WAIT);
  assign rd_acc = avs_read_i && (st_q == TOCC_WAIT);

  // --------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_q <= 5'h00;
      data_q <= 5'h00;
      action_q <= `TOCC_RST_BYTE;
      dir4_q <= 1'b0;
      presc_q <= `TOCC_RST_PRESC;
    end else if (wr_acc && avs_byteenable_i[0]) begin
      unique case (idx)
        `TOCC_OFS_MASK: mask_q <= avs_writedata_i[`TOCC_PIN_MSB:`TOCC_PIN_LSB];
        `TOCC_OFS_DATA: data_q <= avs_writedata_i[`TOCC_PIN_MSB:`TOCC_PIN_LSB];
        `TOCC_OFS_ACTION: action_q <= avs_writedata_i[7:0];
        `TOCC_OFS_ACCUM: dir4_q <= avs_writedata_i[`TOCC_DIR4_BIT];
        `TOCC_OFS_PRESC: presc_q <= avs_writedata_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 5; i++) cmp_q[i] <= `TOCC_RST_WORD;
    end else if (wr_acc && idx >= `TOCC_OFS_CMP1 && idx <= `TOCC_OFS_CMP5) begin
      for (int i = 0; i < 5; i++) begin
        if (idx == `TOCC_OFS_CMP1 + 4'(i)) begin
          cmp_q[i][7:0] <= merge_byte(cmp_q[i][7:0], avs_writedata_i, avs_byteenable_i[0]);
          cmp_q[i][15:8] <= merge_byte(cmp_q[i][15:8], avs_writedata_i >> 8,
            avs_byteenable_i[1]);
        end
      end
    end
  end

  // Force pulse: one cycle per bit written as one
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      force_q <= 5'h00;
    end else if (wr_acc && avs_byteenable_i[0] && idx == `TOCC_OFS_FORCE) begin
      force_q <= {avs_writedata_i[3], avs_writedata_i[4], avs_writedata_i[5],
        avs_writedata_i[6], avs_writedata_i[7]};
    end else begin
      force_q <= 5'h00;
    end
  end

  // --------------------------------------------------------------
  // Prescaled free-running counter and compare
  // --------------------------------------------------------------
  assign tick = (pdiv_q == presc_q);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pdiv_q <= 8'h00;
      cnt_q <= '0;
    end else if (tick) begin
      pdiv_q <= 8'h00;
      cnt_q <= cnt_q + 1'b1;
    end else begin
      pdiv_q <= pdiv_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      match_q <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) match_q[i] <= tick && (cnt_q == cmp_q[i]);
    end
  end

  // Low byte snapshot on the edge that loads the high byte
  assign hi_snap = avs_read_i && (st_q == TOCC_IDLE) && hit_ok && (idx == `TOCC_OFS_CNT_HI);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lo_buf_q <= 8'h00;
    end else if (hi_snap) begin
      lo_buf_q <= cnt_q[7:0];
    end
  end

  // --------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && st_q == TOCC_IDLE) begin
      rdata_q <= 32'h0000_0000;
      if (hit_ok) begin
        unique case (idx)
          `TOCC_OFS_FORCE: rdata_q[7:0] <= 8'h00;
          `TOCC_OFS_MASK: rdata_q[7:0] <= pin_byte(mask_q);
          `TOCC_OFS_DATA: rdata_q[7:0] <= pin_byte(data_q);
          `TOCC_OFS_CNT_HI: rdata_q[7:0] <= cnt_q[15:8];
          `TOCC_OFS_CNT_LO: rdata_q[7:0] <= lo_buf_q;
          `TOCC_OFS_ACTION: rdata_q[7:0] <= action_q;
          `TOCC_OFS_ACCUM: rdata_q[`TOCC_DIR4_BIT] <= dir4_q;
          `TOCC_OFS_CMP1: rdata_q[15:0] <= cmp_q[0];
          `TOCC_OFS_CMP2: rdata_q[15:0] <= cmp_q[1];
          `TOCC_OFS_CMP3: rdata_q[15:0] <= cmp_q[2];
          `TOCC_OFS_CMP4: rdata_q[15:0] <= cmp_q[3];
          `TOCC_OFS_CMP5: rdata_q[15:0] <= cmp_q[4];
          `TOCC_OFS_PRESC: rdata_q[7:0] <= presc_q;
          `TOCC_OFS_PORT: rdata_q[15:0] <= {3'b000, pif.pin_en, pin_byte(pif.pin_q)};
          default: ;
        endcase
      end
    end
  end

  assign avs_readdata_o = rdata_q;

  // --------------------------------------------------------------
  // Action requests to pin logic
  // Pin index 4..0 = port bits 7..3; channel n (2..5) owns bit 8-n
  // --------------------------------------------------------------
  logic ch1_fire;
  logic [4:0] nfire;
  assign ch1_fire = match_q[0] | force_q[0];
  assign nfire[0] = 1'b0;
  assign nfire[4:1] = match_q[4:1] | force_q[4:1];

  assign pif.ch1_hit = ch1_fire ? mask_q : 5'h00;
  assign pif.ch1_val = data_q;
  // Channel 2 -> PA6 (pin 3) ... channel 5 -> PA3 (pin 0)
  assign pif.nch_hit = {1'b0, nfire[1], nfire[2], nfire[3], nfire[4] & ~dir4_q};
  assign pif.nch_act = {2'b00, action_q[7:6], action_q[5:4], action_q[3:2], action_q[1:0]};

  tocc_pin_logic u_pins (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .pif(pif)
  );

  assign port_a_o = pif.pin_q;
  assign port_a_oe_o = pif.pin_en;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence s_force_write;
    wr_acc && avs_byteenable_i[0] && idx == `TOCC_OFS_FORCE && avs_writedata_i[7];
  endsequence

  a_force_fires_ch1: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    s_force_write |=> ch1_fire)
    else $error("force write did not fire channel one");
  a_mask_gates_pin: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ch1_fire && !mask_q[2]) |-> !pif.ch1_hit[2])
    else $error("masked pin driven by channel one");
  a_ch5_dir_block: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    dir4_q |-> !pif.nch_hit[0])
    else $error("channel five acted while direction bit set");
  a_low_bits_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (rd_acc && idx <= `TOCC_OFS_DATA) |-> (avs_readdata_o[2:0] == 3'b000))
    else $error("unimplemented low bits read nonzero");
  a_lo_latched: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    hi_snap |=> (lo_buf_q == $past(cnt_q[7:0])))
    else $error("low byte not latched on high read");
  a_match_pulse: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (tick && cnt_q == cmp_q[1]) |=> match_q[1] ##1 !match_q[1])
    else $error("compare match not a one-cycle pulse");
  a_count_steps: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    tick |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("counter did not advance on prescaler tick");

  sequence s_zero_force;
    wr_acc && avs_byteenable_i[0] && idx == `TOCC_OFS_FORCE && avs_writedata_i[7:3] == 5'h00;
  endsequence

  a_pair_coherent: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    hi_snap |=> ({avs_readdata_o[7:0], lo_buf_q} == $past(cnt_q)))
    else $error("counter halves taken from different counts");
  a_zero_force_idle: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    s_zero_force |=> (force_q == 5'h00))
    else $error("zero force write fired a channel");
  a_ch1_data_pin: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ch1_fire && mask_q[0]) |=> (port_a_oe_o[0] && port_a_o[0] == $past(data_q[0])))
    else $error("channel one data not on unmasked pin");
  a_low_clears_pin: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (pif.nch_hit[2] && !pif.ch1_hit[2] && pif.nch_act[5:4] == `TOCC_ACT_LOW)
    |=> (port_a_oe_o[2] && !port_a_o[2]))
    else $error("clear action did not drive pin low");
  a_off_releases: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (pif.nch_hit[3] && !pif.ch1_hit[3] && pif.nch_act[7:6] == `TOCC_ACT_OFF)
    |=> !port_a_oe_o[3])
    else $error("disconnect action left pin driven");
endmodule : tocc_top
`default_nettype wire

/* File: tocc_pin_model.sv */
// Far-side model of the five port A pins driven by the compare block.
// Assumes a pull-up on each pin, so a released pin reads high.
`timescale 1ns/10ps
`default_nettype none
module tocc_pin_model (
  input wire logic [4:0] port_a_i,
  input wire logic [4:0] port_a_oe_i,
  output logic [4:0] pin_level_o
);
  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  // Driven pins follow the timer, released pins float high
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_level_o[i] = port_a_oe_i[i] ? port_a_i[i] : 1'b1;
    end
  end
endmodule : tocc_pin_model
`default_nettype wire

/* File: tb_timer_output_compare_control.sv */
// Self-checking bench for the output-compare control block.
// Assumes tocc_pkg, tocc_top and tocc_pin_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_timer_output_compare_control;
  import tocc_pkg::*;
  logic core_clk_i;
  logic rstn_i;
  logic [5:0] address;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic waitreq;
  logic [4:0] pa;
  logic [4:0] pa_oe;
  logic [4:0] pin_level;
  int mismatches;
  int check_count;
  int cycle_cnt;
  int acc_cycle;
  logic [15:0] last_rd;
  tocc_top dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(address),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .port_a_o(pa), .port_a_oe_o(pa_oe));
  tocc_pin_model pins (.port_a_i(pa), .port_a_oe_i(pa_oe), .pin_level_o(pin_level));
  // ----------------------------------------
  // Clock, reset and timeout
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : chk
  task automatic bus_op(input logic is_wr, input logic [3:0] idx, input logic [15:0] d,
    output logic [7:0] q);
    @(posedge core_clk_i);
    address <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    rd <= ~is_wr;
    wr <= is_wr;
    do begin
      @(posedge core_clk_i);
    end while (waitreq !== 1'b0);
    acc_cycle = cycle_cnt;
    q = rdata[7:0];
    last_rd = rdata[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus_op
  task automatic wr_reg(input logic [3:0] idx, input logic [15:0] d);
    logic [7:0] q;
    bus_op(1'b1, idx, d, q);
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] idx, output logic [7:0] q);
    bus_op(1'b0, idx, 16'h0000, q);
  endtask : rd_reg
  task automatic settle();
    repeat (3) @(posedge core_clk_i);
  endtask : settle
  // High byte first, then low byte after a chosen gap
  task automatic read_count(input int gap, output logic [15:0] v, output int at);
    logic [7:0] hi;
    logic [7:0] lo;
    rd_reg(4'h3, hi);
    at = acc_cycle;
    repeat (gap) @(posedge core_clk_i);
    rd_reg(4'h4, lo);
    v = {hi, lo};
  endtask : read_count
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_regs();
    logic [7:0] b;
    wr_reg(4'h1, 16'h00ff);
    rd_reg(4'h1, b);
    chk("mask", 16'h00f8, 16'(b));
    wr_reg(4'h2, 16'h00ff);
    rd_reg(4'h2, b);
    chk("data", 16'h00f8, 16'(b));
    wr_reg(4'h0, 16'h0000);
    settle();
    chk("pins after zero force", 16'h0000, 16'(pa));
    rd_reg(4'h0, b);
    chk("force", 16'h0000, 16'(b));
    wr_reg(4'h5, 16'h00a5);
    rd_reg(4'h5, b);
    chk("action", 16'h00a5, 16'(b));
    rd_reg(4'he, b);
    chk("unmapped", 16'h0000, 16'(b));
    $display("done: regs");
  endtask : test_regs
  task automatic test_ch1();
    wr_reg(4'h1, 16'h00a8);
    wr_reg(4'h2, 16'h0088);
    wr_reg(4'h0, 16'h0080);
    settle();
    chk("ch1 pins a", 16'h0011, 16'(pa));
    wr_reg(4'h2, 16'h0078);
    wr_reg(4'h0, 16'h0080);
    settle();
    chk("ch1 pins b", 16'h0005, 16'(pa));
    wr_reg(4'h1, 16'h0000);
    $display("done: ch1");
  endtask : test_ch1
  task automatic test_actions();
    logic [1:0] code [5] = '{2'b10, 2'b11, 2'b01, 2'b01, 2'b00};
    logic [3:0] exp;
    exp = 4'h5;
    for (int i = 0; i < 5; i++) begin
      wr_reg(4'h5, {8'h00, {4{code[i]}}});
      wr_reg(4'h0, 16'h0078);
      settle();
      exp = (code[i] == 2'b10) ? 4'h0 : (code[i] == 2'b11) ? 4'hf : ~exp;
      chk("action oe", {12'h000, {4{code[i] != 2'b00}}}, 16'(pa_oe[3:0]));
      if (code[i] != 2'b00) begin
        chk("action pins", 16'(exp), 16'(pin_level[3:0]));
      end
    end
    wr_reg(4'h5, 16'h0002);
    wr_reg(4'h6, 16'h0004);
    wr_reg(4'h0, 16'h0008);
    settle();
    chk("ch5 blocked oe", 16'h0000, 16'(pa_oe[0]));
    wr_reg(4'h6, 16'h0000);
    wr_reg(4'h0, 16'h0008);
    settle();
    chk("ch5 pin", 16'h0002, {14'h0000, pa_oe[0], pa[0]});
    $display("done: actions");
  endtask : test_actions
  task automatic test_counter();
    logic [15:0] v1;
    logic [15:0] v2;
    logic [7:0] b;
    int c1;
    int c2;
    read_count(0, v1, c1);
    // Count steps every clock from the third edge; taken one edge before accept
    chk("count abs", 16'(c1 - 3), v1);
    wr_reg(4'h3, 16'h0000);
    read_count(40, v2, c2);
    chk("count step", v1 + 16'(c2 - c1), v2);
    rd_reg(4'h4, b);
    chk("low held", 16'(v2[7:0]), 16'(b));
    $display("done: counter");
  endtask : test_counter
  task automatic test_match();
    logic [15:0] v;
    logic [7:0] b;
    int c;
    read_count(0, v, c);
    wr_reg(4'h5, 16'h0040);
    wr_reg(4'h8, v + 16'd300);
    while (cycle_cnt < c + 290) @(posedge core_clk_i);
    chk("before match", 16'h0001, 16'(pa[3]));
    while (cycle_cnt < c + 310) @(posedge core_clk_i);
    chk("after match", 16'h0002, {14'h0000, pa_oe[3], pa[3]});
    rd_reg(4'h8, b);
    chk("cmp2 value", v + 16'd300, last_rd);
    $display("done: match");
  endtask : test_match
  task automatic test_status();
    logic [7:0] b;
    rd_reg(4'hd, b);
    chk("port status", 16'h1930, last_rd);
    wr_reg(4'hc, 16'h0003);
    rd_reg(4'hc, b);
    chk("prescaler", 16'h0003, 16'(b));
    wr_reg(4'h6, 16'h0004);
    rd_reg(4'h6, b);
    chk("direction", 16'h0004, 16'(b));
    $display("done: status");
  endtask : test_status
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rstn_i = 1'b0;
    address = 6'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0000_0000;
    mismatches = 0;
    check_count = 0;
    cycle_cnt = 0;
    acc_cycle = 0;
    last_rd = 16'h0000;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    test_regs();
    test_ch1();
    test_actions();
    test_counter();
    test_match();
    test_status();
    test_done();
  end
endmodule : tb_timer_output_compare_control
`default_nettype wire
